// *** bench/test_cmk_top.sv ***
// Self-checking bench for the command-mask transfer engine.
// Assumes the design top on the plain register port, one clock, async reset.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  errors++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module test_cmk_top import cmk_pkg::*; ();
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        busy;
  int          errors    = 0;
  int          cmp_count = 0;
  int          seed      = 30;
  logic [31:0] m_arb [CMK_OBJ_CNT];
  logic [15:0] m_ctl [CMK_OBJ_CNT];
  logic [31:0] b_arb;
  logic [15:0] b_ctl;
  logic [1:0]  m_stat;
  logic [1:0]  m_imask;
  logic [7:0]  msk;
  logic [31:0] d;
  int          idx;

  always #20 clock = ~clock;

  cmk_top #(.OBJS(CMK_OBJ_CNT)) i_cmk_top (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .busy(busy));

  // ----------------------------------------------------------------
  // Bus cycles and checks
  // ----------------------------------------------------------------
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chkbuf;
    rreg(CMK_OFS_ARB, d);
    `CHK("arb buffer", b_arb, d)
    rreg(CMK_OFS_MCTL, d);
    `CHK("control buffer", b_ctl, d[15:0])
    rreg(CMK_OFS_MASK, d);
    `CHK("command mask", {24'h00_0000, msk}, d)
  endtask

  // Start a transfer and mirror its effect in the model
  task automatic xfer(input int i);
    wreg(CMK_OFS_CRQ, 32'(i));
    #1 `CHK("busy", 1'b1, busy)
    if (msk[CMK_BIT_WRNRD]) begin
      if (msk[CMK_BIT_ARB]) m_arb[i] = b_arb;
      if (msk[CMK_BIT_CTRL]) m_ctl[i] = b_ctl;
      if (msk[CMK_BIT_TXNEW]) m_ctl[i][CMK_MCTL_TXREQ] = 1'b1;
    end else begin
      if (msk[CMK_BIT_ARB]) b_arb = m_arb[i];
      if (msk[CMK_BIT_CTRL]) b_ctl = m_ctl[i];
      if (msk[CMK_BIT_CLRPND]) m_ctl[i][CMK_MCTL_PENDING] = 1'b0;
      if (msk[CMK_BIT_TXNEW]) m_ctl[i][CMK_MCTL_NEWDATA] = 1'b0;
    end
    m_stat |= msk[CMK_BIT_WRNRD] ? 2'h1 : 2'h2;
    @(posedge clock);
    #1 `CHK("busy end", 1'b0, busy)
    `CHK("irq", |(m_stat & m_imask), irq)
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    m_stat = 2'h0;
    msk    = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a <= 20; a += 4) begin
      rreg(8'(a), d);
      `CHK("reset value", 32'h0000_0000, d)
    end
    for (int n = 0; n < 24; n++) begin
      idx = $unsigned($random(seed)) % CMK_OBJ_CNT;
      m_imask = 2'($random(seed));
      wreg(CMK_OFS_IMASK, {30'h0000_0000, m_imask});
      // Two writes then two reads; first write fills the whole object
      for (int k = 0; k < 4; k++) begin
        b_arb = $random(seed);
        b_ctl = 16'($random(seed));
        wreg(CMK_OFS_ARB, b_arb);
        wreg(CMK_OFS_MCTL, {16'h0000, b_ctl});
        msk = 8'($random(seed)) & 8'h3c;
        if (k == 0) msk = msk | 8'h30;
        msk[CMK_BIT_WRNRD] = (k < 2);
        wreg(CMK_OFS_MASK, {24'h00_0000, msk});
        chkbuf;
        xfer(idx);
        chkbuf;
      end
      rreg(CMK_OFS_STAT, d);
      `CHK("status", {30'h0000_0000, m_stat}, d)
      m_stat = 2'h0;
      @(posedge clock);
      #1 `CHK("irq cleared", 1'b0, irq)
    end
    wreg(8'h18, $random(seed));
    rreg(8'h18, d);
    `CHK("unmapped read", 32'h0000_0000, d)
    end_sim;
  end

  // Hang guard: far beyond the few thousand cycles the run needs
  initial begin
    #(40 * 20000);
    errors++;
    end_sim;
  end
endmodule

// *** hw/cmk_evt.sv ***
// Sticky event status with mask and read-to-clear.
// Assumes events are one-cycle pulses on the block clock.
`timescale 1ns/10ps
module cmk_evt import cmk_pkg::*; #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Events and software access
  input  wire logic [N-1:0] evt,
  input  wire logic         stat_rd,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_wdata,
  // Results
  output logic      [N-1:0] stat,
  output logic      [N-1:0] mask,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] stat_reg;
    logic [N-1:0] mask_reg;
  } cmk_evt_st_t;

  cmk_evt_st_t st_reg;
  cmk_evt_st_t st_next;

  // Set wins over the read clear
  always_comb begin
    st_next          = st_reg;
    if (stat_rd) begin
      st_next.stat_reg = '0;
    end
    st_next.stat_reg = st_next.stat_reg | evt;
    if (mask_wr) begin
      st_next.mask_reg = mask_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stat = st_reg.stat_reg;
  assign mask = st_reg.mask_reg;
  assign irq  = |(st_reg.stat_reg & st_reg.mask_reg);

  sticky_set_a: assert property (@(posedge clock) disable iff (rst)
    evt[0] |=> stat[0])
    else $error("event not latched");
endmodule

// *** hw/cmk_top.sv ***
// Command-mask transfer engine between interface buffers and object RAM.
// Assumes software uses the plain register port; one clock domain.
//
// Contract
// - Read with arbitration select copies id, dir, xtd, valid into buffer.
// - Write with control select copies buffer control into object control.
// - Read with control select copies object control into buffer control.
// - Clear-pending select clears the object's interrupt pending flag.
// - Clear-pending select is ignored on write transfers.
// - Bit 2 selects transmit request on writes, new data on reads.
`timescale 1ns/10ps
module cmk_top import cmk_pkg::*; #(
  parameter int OBJS = CMK_OBJ_CNT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Interrupt and status
  output logic             irq,
  output logic             busy
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           mask_reg;
    cmk_arb_t             arb_reg;
    logic [15:0]          mctl_reg;
    logic [31:0]          rdata_reg;
    logic                 go_reg;
    logic [CMK_IDX_W-1:0] idx_reg;
  } cmk_st_t;

  cmk_st_t  st_reg;
  cmk_st_t  st_next;
  cmk_obj_t ram [OBJS];
  cmk_obj_t obj;
  cmk_obj_t obj_next;
  logic     ram_we;
  logic [1:0] evt;
  logic [1:0] stat;
  logic [1:0] imask;
  logic       wrnrd;

  assign obj   = ram[st_reg.idx_reg];
  assign wrnrd = st_reg.mask_reg[CMK_BIT_WRNRD];

  // ----------------------------------------------------------------
  // Transfer and register logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    obj_next         = obj;
    ram_we           = 1'b0;
    evt              = 2'h0;
    st_next.go_reg   = 1'b0;
    st_next.rdata_reg = 32'h0000_0000;
    if (st_reg.go_reg) begin
      ram_we = 1'b1;
      if (wrnrd) begin
        if (st_reg.mask_reg[CMK_BIT_ARB]) begin
          obj_next.arb = st_reg.arb_reg;
        end
        if (st_reg.mask_reg[CMK_BIT_CTRL]) begin
          obj_next.ctrl = st_reg.mctl_reg;
        end
        if (st_reg.mask_reg[CMK_BIT_TXNEW]) begin
          obj_next.ctrl[CMK_MCTL_TXREQ] = 1'b1;
        end
        evt[0] = 1'b1;
      end else begin
        if (st_reg.mask_reg[CMK_BIT_ARB]) begin
          st_next.arb_reg = obj.arb;
        end
        if (st_reg.mask_reg[CMK_BIT_CTRL]) begin
          st_next.mctl_reg = obj.ctrl;
        end
        if (st_reg.mask_reg[CMK_BIT_CLRPND]) begin
          obj_next.ctrl[CMK_MCTL_PENDING] = 1'b0;
        end
        if (st_reg.mask_reg[CMK_BIT_TXNEW]) begin
          obj_next.ctrl[CMK_MCTL_NEWDATA] = 1'b0;
        end
        evt[1] = 1'b1;
      end
    end
    if (wr) begin
      unique case (addr)
        CMK_OFS_MASK: st_next.mask_reg = wdata[7:0];
        CMK_OFS_CRQ: begin
          st_next.idx_reg = wdata[CMK_IDX_W-1:0];
          st_next.go_reg  = 1'b1;
        end
        CMK_OFS_ARB:  st_next.arb_reg  = wdata;
        CMK_OFS_MCTL: st_next.mctl_reg = wdata[15:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        CMK_OFS_MASK:  st_next.rdata_reg = {24'h000000, st_reg.mask_reg};
        CMK_OFS_CRQ:   st_next.rdata_reg = {26'h0, st_reg.go_reg,
                                            st_reg.idx_reg};
        CMK_OFS_ARB:   st_next.rdata_reg = st_reg.arb_reg;
        CMK_OFS_MCTL:  st_next.rdata_reg = {16'h0000, st_reg.mctl_reg};
        CMK_OFS_STAT:  st_next.rdata_reg = {30'h0, stat};
        CMK_OFS_IMASK: st_next.rdata_reg = {30'h0, imask};
        default:       st_next.rdata_reg = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '{mask_reg: CMK_MASK_RST, arb_reg: CMK_ARB_RST,
                  mctl_reg: CMK_MCTL_RST, rdata_reg: 32'h0000_0000,
                  go_reg: 1'b0, idx_reg: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Object RAM has no reset; software initialises it
  always_ff @(posedge clock) begin
    if (ram_we) begin
      ram[st_reg.idx_reg] <= obj_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  cmk_evt #(.N(2)) u_evt (
    .clock      (clock),
    .rst        (rst),
    .evt        (evt),
    .stat_rd    (rd && addr == CMK_OFS_STAT),
    .mask_wr    (wr && addr == CMK_OFS_IMASK),
    .mask_wdata (wdata[1:0]),
    .stat       (stat),
    .mask       (imask),
    .irq        (irq)
  );

  assign rdata = st_reg.rdata_reg;
  assign busy  = st_reg.go_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_arb_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && st_reg.mask_reg[CMK_BIT_ARB] && !wr
    |=> st_reg.arb_reg == $past(obj.arb))
    else $error("arbitration not copied on read");
  write_ctrl_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && wrnrd && st_reg.mask_reg[CMK_BIT_CTRL]
    && !st_reg.mask_reg[CMK_BIT_TXNEW]
    |=> ram[$past(st_reg.idx_reg)].ctrl == $past(st_reg.mctl_reg))
    else $error("control not written to object");
  read_ctrl_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && st_reg.mask_reg[CMK_BIT_CTRL] && !wr
    |=> st_reg.mctl_reg == $past(obj.ctrl))
    else $error("control not read to buffer");
  clr_pend_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && st_reg.mask_reg[CMK_BIT_CLRPND]
    |=> !ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_PENDING])
    else $error("pending flag not cleared");
  pend_hold_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && !st_reg.mask_reg[CMK_BIT_CLRPND]
    |=> ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_PENDING]
        == $past(obj.ctrl[CMK_MCTL_PENDING]))
    else $error("pending flag changed without select");
  pend_keep_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && wrnrd && !st_reg.mask_reg[CMK_BIT_CTRL]
    |=> ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_PENDING]
        == $past(obj.ctrl[CMK_MCTL_PENDING]))
    else $error("pending flag touched on write");
  txreq_set_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && wrnrd && st_reg.mask_reg[CMK_BIT_TXNEW]
    |=> ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_TXREQ])
    else $error("transmit request not set");
  no_start_a: assert property (@(posedge clock) disable iff (rst)
    !st_reg.go_reg && !(wr && addr == CMK_OFS_ARB)
    |=> st_reg.arb_reg == $past(st_reg.arb_reg))
    else $error("buffer changed without transfer");
  start_go_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == CMK_OFS_CRQ |=> busy)
    else $error("transfer not started");
  busy_only_a: assert property (@(posedge clock) disable iff (rst)
    !(wr && addr == CMK_OFS_CRQ) |=> !busy)
    else $error("busy without command request");
  arb_hold_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && !st_reg.mask_reg[CMK_BIT_ARB] && !wr
    |=> st_reg.arb_reg == $past(st_reg.arb_reg))
    else $error("arbitration buffer changed without select");
  obj_arb_keep_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd
    |=> ram[$past(st_reg.idx_reg)].arb == $past(obj.arb))
    else $error("object arbitration changed on read");
  obj_ctrl_hold_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && wrnrd && !st_reg.mask_reg[CMK_BIT_CTRL]
    && !st_reg.mask_reg[CMK_BIT_TXNEW]
    |=> ram[$past(st_reg.idx_reg)].ctrl == $past(obj.ctrl))
    else $error("object control changed without select");
  ctrl_hold_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && !st_reg.mask_reg[CMK_BIT_CTRL] && !wr
    |=> st_reg.mctl_reg == $past(st_reg.mctl_reg))
    else $error("control buffer changed without select");
  fresh_clr_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd && st_reg.mask_reg[CMK_BIT_TXNEW]
    |=> !ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_NEWDATA])
    else $error("new data flag not cleared");
  txreq_keep_a: assert property (@(posedge clock) disable iff (rst)
    st_reg.go_reg && !wrnrd
    |=> ram[$past(st_reg.idx_reg)].ctrl[CMK_MCTL_TXREQ]
        == $past(obj.ctrl[CMK_MCTL_TXREQ]))
    else $error("transmit request touched on read");
  rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule

// *** include/cmk_pkg.sv ***
// Package for the interface command-mask transfer block.
// Assumes a single clock domain and a plain register port.
package cmk_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMK_OFS_MASK   = 8'h00;
  localparam logic [7:0] CMK_OFS_CRQ    = 8'h04;
  localparam logic [7:0] CMK_OFS_ARB    = 8'h08;
  localparam logic [7:0] CMK_OFS_MCTL   = 8'h0c;
  localparam logic [7:0] CMK_OFS_STAT   = 8'h10;
  localparam logic [7:0] CMK_OFS_IMASK  = 8'h14;

  // ----------------------------------------------------------------
  // Command mask field positions
  // ----------------------------------------------------------------
  localparam int CMK_BIT_WRNRD   = 7;
  localparam int CMK_BIT_ARB     = 5;
  localparam int CMK_BIT_CTRL    = 4;
  localparam int CMK_BIT_CLRPND  = 3;
  localparam int CMK_BIT_TXNEW   = 2;

  // ----------------------------------------------------------------
  // Message control word field positions
  // ----------------------------------------------------------------
  localparam int CMK_MCTL_NEWDATA = 15;
  localparam int CMK_MCTL_PENDING = 13;
  localparam int CMK_MCTL_TXREQ   = 8;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMK_MASK_RST  = 8'h00;
  localparam logic [15:0] CMK_MCTL_RST  = 16'h0000;
  localparam logic [31:0] CMK_ARB_RST   = 32'h0000_0000;
  localparam logic [1:0]  CMK_IRQ_RST   = 2'h0;
  localparam int          CMK_OBJ_CNT   = 32;
  localparam int          CMK_IDX_W     = 5;

  // Arbitration word: valid, extended, direction, 29-bit identifier
  typedef struct packed {
    logic        object_valid_flag;
    logic        xtd;
    logic        dir;
    logic [28:0] id;
  } cmk_arb_t;

  // One message object in the RAM
  typedef struct packed {
    cmk_arb_t    arb;
    logic [15:0] ctrl;
  } cmk_obj_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cmk_bus_t;

endpackage
